// file: rtl/profiling_sample_selector.sv
// Profiling sample selector: interval counters, enable logic and record filters
//
// Contract
// R1: Profiling is off after reset; user level cannot change control settings.
// R2: Enabling with nonzero count state resumes from held values.
// R3: Enabling with zero count loads interval high, low byte zero or random.
// R4: Without randomization, count down per member; at zero select and reload.
// R5: Randomization, mode 0: reload low byte with a random value.
// R6: Randomization, mode 1: primary zero reloads and loads secondary randomly.
// R7: Secondary counts with primary; member reaching its zero is selected.
// R8: While disabled, select nothing, collect nothing, counters hold.
// R9: Collision raises collision event and sets the collision flag.
// R10: Collision flag visibility is only guaranteed after context synchronization.
// R11: Disabled by buffer off, service flag, higher level, other security, debug.
// R12: Per-level enable bits gate sampling for guest and host regimes.
// R13: Type filter keeps only enabled loads, stores, branches; others discarded.
// R14: Stores include all atomics; loads returning atomics; branches all kinds.
// R15: Event filter keeps records holding every event set in the mask.
// R16: Latency filter keeps records with latency at least the minimum.
// R17: Enabled filters combine by logical AND.
// R18: Records failing filters are never written out.
// R19: Collision when sampling while previous record is still pending.
// R20: Random bytes come from a free-running maximal-length LFSR.
`timescale 1ns/1ps
module profiling_sample_selector
  import sample_sel_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Control writes from privileged software
  input wire logic ctrl_write_i,
  input wire logic [1:0] writer_level_i,
  input wire logic [INTERVAL_W-1:0] interval_reload_setting_i,
  input wire logic randomize_enable_i,
  input wire logic kernel_level_sample_enable_i,
  input wire logic user_level_sample_enable_i,
  input wire logic hyp_level_sample_enable_i,
  input wire logic host_user_sample_enable_i,
  input wire logic type_filter_enable_i,
  input wire logic load_collect_i,
  input wire logic store_collect_i,
  input wire logic branch_collect_i,
  input wire logic event_filter_enable_i,
  input wire logic [EVENT_W-1:0] event_filter_mask_i,
  input wire logic latency_filter_enable_i,
  input wire logic [LAT_W-1:0] minimum_latency_i,
  // Implementation choice and buffer state
  input wire logic extended_random_mode_i,
  input wire logic buffer_enable_i,
  input wire logic buffer_service_i,
  input wire logic collision_clear_i,
  // Owner and execution context
  input wire logic owner_security_select_i,
  input wire logic owner_level_select_i,
  input wire logic nonsecure_state_bit_i,
  input wire logic host_general_trap_i,
  input wire logic [1:0] exec_level_i,
  input wire logic debug_state_i,
  // Pipeline population and records
  input wire logic member_valid_i,
  input wire logic record_valid_i,
  input wire op_class_t record_class_i,
  input wire logic [EVENT_W-1:0] record_events_i,
  input wire logic [LAT_W-1:0] record_latency_i,
  // Results
  output logic profiling_enabled_o,
  output logic sample_select_o,
  output logic record_keep_o,
  output logic record_drop_o,
  output logic collision_event_o,
  output logic collision_flag_o,
  output logic [COUNT_W-1:0] interval_count_state_o,
  output logic [RAND_W-1:0] secondary_interval_counter_o
);
  // Control settings held inside the block
  logic [INTERVAL_W-1:0] interval;
  logic rnd_on, k_en, u_en, h_en, hu_en;
  logic ft_en, ld_col, st_col, br_col, fe_en, fl_en;
  logic [EVENT_W-1:0] ev_mask;
  logic [LAT_W-1:0] min_lat;
  logic [COUNT_W-1:0] count;
  logic [RAND_W-1:0] second;
  logic enabled, enabled_q, pending, collision_flag_flag, collision_flag_pulse;
  logic keep_q, drop_q, select_q;
  logic [RAND_W-1:0] rand_byte;
  logic in_host, owner_ns, owner_hyp, level_bit, member;
  logic primary_zero, second_zero, select_now;
  logic [COUNT_W-1:0] reload_value;

  function automatic op_type_t classify(input op_class_t c);
    case (c)
      CLS_LOAD, CLS_ATOMIC_RET: classify = OP_LOAD; // [R14]
      CLS_STORE, CLS_ATOMIC_NORET: classify = OP_STORE; // [R14]
      CLS_BR_DIRECT, CLS_BR_INDIRECT, CLS_EXC_RETURN: classify = OP_BRANCH; // [R14]
      default: classify = OP_OTHER;
    endcase
  endfunction

  function automatic logic [COUNT_W-1:0] reload_with(input logic [INTERVAL_W-1:0] high,
                                                     input logic [RAND_W-1:0] low);
    reload_with = {high, low};
  endfunction

  random_byte_lfsr u_rng (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .rand_o(rand_byte)
  );

  // Control settings: off after reset, user-level writes ignored
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      interval <= '0; // [R1]
      rnd_on <= 1'b0;
      k_en <= 1'b0; // [R1]
      u_en <= 1'b0;
      h_en <= 1'b0;
      hu_en <= 1'b0;
      ft_en <= 1'b0;
      ld_col <= 1'b0;
      st_col <= 1'b0;
      br_col <= 1'b0;
      fe_en <= 1'b0;
      ev_mask <= '0;
      fl_en <= 1'b0;
      min_lat <= '0;
    end else if (ctrl_write_i && writer_level_i != LEVEL_USER) begin // [R1]
      interval <= interval_reload_setting_i;
      rnd_on <= randomize_enable_i;
      k_en <= kernel_level_sample_enable_i;
      u_en <= user_level_sample_enable_i;
      h_en <= hyp_level_sample_enable_i;
      hu_en <= host_user_sample_enable_i;
      ft_en <= type_filter_enable_i;
      ld_col <= load_collect_i;
      st_col <= store_collect_i;
      br_col <= branch_collect_i;
      fe_en <= event_filter_enable_i;
      ev_mask <= event_filter_mask_i;
      fl_en <= latency_filter_enable_i;
      min_lat <= minimum_latency_i;
    end
  end

  // Enable decision
  assign owner_ns = owner_security_select_i;
  assign owner_hyp = owner_ns && owner_level_select_i;
  assign in_host = nonsecure_state_bit_i && host_general_trap_i;
  always_comb begin
    case (exec_level_i)
      LEVEL_HYP: level_bit = h_en; // [R12]
      LEVEL_KERNEL: level_bit = k_en; // [R12]
      LEVEL_USER: level_bit = in_host ? hu_en : u_en; // [R12]
      default: level_bit = 1'b0;
    endcase
  end
  assign enabled = buffer_enable_i && !buffer_service_i && !debug_state_i // [R11]
    && (exec_level_i <= (owner_hyp ? LEVEL_HYP : LEVEL_KERNEL)) // [R11]
    && (owner_ns == nonsecure_state_bit_i) // [R11]
    && !(in_host && !owner_hyp) && level_bit;

  assign member = enabled && member_valid_i; // [R8]
  assign primary_zero = (count == COUNT_RESET);
  assign second_zero = (second == SECONDARY_RESET);
  assign reload_value = reload_with(interval, (rnd_on && !extended_random_mode_i) ? rand_byte
                                    : LOW_RELOAD); // [R3] [R4] [R5]
  always_comb begin
    if (rnd_on && extended_random_mode_i) begin
      select_now = member && !second_zero && (second == 8'h01); // [R7]
    end else begin
      select_now = member && (count == 32'h0000_0001); // [R4]
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      enabled_q <= 1'b0;
    end else begin
      enabled_q <= enabled;
    end
  end

  // Primary counter
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      count <= COUNT_RESET;
    end else if (enabled && !enabled_q && primary_zero) begin // [R2] [R3]
      count <= reload_value; // [R3]
    end else if (member) begin
      if (count == 32'h0000_0001 || primary_zero) begin
        count <= reload_value; // [R4] [R5] [R6]
      end else begin
        count <= count - 32'h0000_0001; // [R4]
      end
    end
  end

  // Secondary counter
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      second <= SECONDARY_RESET;
    end else if (member && rnd_on && extended_random_mode_i) begin
      if (count == 32'h0000_0001 || primary_zero) begin
        second <= rand_byte; // [R6]
      end else if (!second_zero) begin
        second <= second - 8'h01; // [R7]
      end
    end
  end

  // Pending record and collision
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pending <= 1'b0;
    end else if (select_now) begin
      pending <= 1'b1; // [R19]
    end else if (record_valid_i) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      collision_flag_pulse <= 1'b0;
      collision_flag_flag <= 1'b0;
    end else begin
      collision_flag_pulse <= select_now && pending && !record_valid_i; // [R9] [R19]
      if (select_now && pending && !record_valid_i) begin
        collision_flag_flag <= 1'b1; // [R9] set wins over clear
      end else if (collision_clear_i) begin
        collision_flag_flag <= 1'b0; // [R10] direct register update, visible on collision_flag_o after the next clock edge
      end
    end
  end

  // Record filters
  logic type_ok, event_ok, lat_ok, pass;
  op_type_t op_kind;
  always_comb begin
    op_kind = classify(record_class_i);
    case (op_kind)
      OP_LOAD: type_ok = ld_col; // [R13]
      OP_STORE: type_ok = st_col; // [R13]
      OP_BRANCH: type_ok = br_col; // [R13]
      default: type_ok = 1'b0; // [R13]
    endcase
    // Value-returning atomics count as both load and store
    if (record_class_i == CLS_ATOMIC_RET) begin
      type_ok = ld_col || st_col; // [R14]
    end
    if (!ft_en) begin
      type_ok = 1'b1; // [R13]
    end
  end
  assign event_ok = !fe_en || ((ev_mask & ~record_events_i) == '0); // [R15]
  assign lat_ok = !fl_en || (record_latency_i >= min_lat); // [R16]
  assign pass = type_ok && event_ok && lat_ok; // [R17]

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      keep_q <= 1'b0;
      drop_q <= 1'b0;
      select_q <= 1'b0;
    end else begin
      keep_q <= enabled && record_valid_i && pending && pass; // [R8] [R18]
      drop_q <= record_valid_i && pending && !(enabled && pass); // [R18]
      select_q <= select_now;
    end
  end

  assign profiling_enabled_o = enabled;
  assign sample_select_o = select_q;
  assign record_keep_o = keep_q;
  assign record_drop_o = drop_q;
  assign collision_event_o = collision_flag_pulse;
  assign collision_flag_o = collision_flag_flag;
  assign interval_count_state_o = count;
  assign secondary_interval_counter_o = second;

  // Checks
  sequence s_member_disabled;
    member_valid_i && !enabled;
  endsequence
  sequence s_counter_hold;
    $stable(count) && $stable(second);
  endsequence

  property p_hold_disabled;
    @(posedge clock_i) disable iff (srst_i)
      s_member_disabled |=> s_counter_hold;
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("counter moved"); // [R8]

  property p_no_select_disabled;
    @(posedge clock_i) disable iff (srst_i) !enabled |=> !sample_select_o;
  endproperty
  a_no_select_disabled: assert property (p_no_select_disabled) // [R8]
    else $error("select while disabled");

  property p_decrement;
    @(posedge clock_i) disable iff (srst_i)
      member && count > 32'h0000_0001 && enabled_q |=> count == $past(count) - 32'h0000_0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("no decrement"); // [R4]

  property p_reload;
    @(posedge clock_i) disable iff (srst_i)
      member && count == 32'h0000_0001 && !rnd_on && enabled_q
      |=> count == {$past(interval), 8'h00} && sample_select_o;
  endproperty
  a_reload: assert property (p_reload) else $error("bad reload"); // [R4]

  property p_resume;
    @(posedge clock_i) disable iff (srst_i)
      enabled && !enabled_q && !primary_zero && !member_valid_i |=> $stable(count);
  endproperty
  a_resume: assert property (p_resume) else $error("reloaded on resume"); // [R2]

  property p_collision_flag_flag;
    @(posedge clock_i) disable iff (srst_i)
      select_now && pending && !record_valid_i |=> collision_flag_o && collision_event_o;
  endproperty
  a_collision_flag_flag: assert property (p_collision_flag_flag) else $error("collision missed"); // [R9]

  property p_user_write;
    @(posedge clock_i) disable iff (srst_i)
      ctrl_write_i && writer_level_i == LEVEL_USER |=> $stable(k_en) && $stable(interval);
  endproperty
  a_user_write: assert property (p_user_write) else $error("user write took"); // [R1]

  property p_debug_off;
    @(posedge clock_i) disable iff (srst_i) debug_state_i || !buffer_enable_i |-> !enabled;
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("enabled when blocked"); // [R11]

  property p_filter_and;
    @(posedge clock_i) disable iff (srst_i) record_keep_o |-> !record_drop_o
      && $past(pass) && $past(lat_ok) && $past(event_ok) && $past(type_ok);
  endproperty
  a_filter_and: assert property (p_filter_and) else $error("bad keep"); // [R17] [R18]

  property p_second;
    @(posedge clock_i) disable iff (srst_i)
      member && rnd_on && extended_random_mode_i && second == 8'h01 && count > 32'h0000_0001
      |=> second == 8'h00 && sample_select_o;
  endproperty
  a_second: assert property (p_second) else $error("secondary select missed"); // [R7]
endmodule

// file: rtl/sample_sel_pkg.sv
// Shared constants and types for the profiling sample selector
package sample_sel_pkg;
  localparam int COUNT_W = 32;
  localparam int INTERVAL_W = 24;
  localparam int RAND_W = 8;
  localparam int EVENT_W = 64;
  localparam int LAT_W = 12;
  localparam int LOW_LSB = 0;
  localparam int LOW_MSB = 7;
  localparam int HIGH_LSB = 8;
  localparam int HIGH_MSB = 31;
  localparam logic [7:0] LOW_RELOAD = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;
  // Privilege levels
  localparam logic [1:0] LEVEL_USER = 2'h0;
  localparam logic [1:0] LEVEL_KERNEL = 2'h1;
  localparam logic [1:0] LEVEL_HYP = 2'h2;
  localparam logic [1:0] LEVEL_TOP = 2'h3;
  typedef enum logic [3:0] {
    OP_OTHER = 4'b0001,
    OP_LOAD = 4'b0010,
    OP_STORE = 4'b0100,
    OP_BRANCH = 4'b1000
  } op_type_t;
  // Raw operation classes presented by the pipeline
  typedef enum logic [2:0] {
    CLS_OTHER = 3'h0,
    CLS_LOAD = 3'h1,
    CLS_STORE = 3'h2,
    CLS_ATOMIC_RET = 3'h3,
    CLS_ATOMIC_NORET = 3'h4,
    CLS_BR_DIRECT = 3'h5,
    CLS_BR_INDIRECT = 3'h6,
    CLS_EXC_RETURN = 3'h7
  } op_class_t;
endpackage

// file: rtl/random_byte_lfsr.sv
// Free-running maximal-length byte LFSR
`timescale 1ns/1ps
module random_byte_lfsr
  import sample_sel_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Random value
  output logic [RAND_W-1:0] rand_o
);
  logic [RAND_W-1:0] state;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= LFSR_SEED;
    end else if (state[0]) begin
      state <= (state >> 1) ^ LFSR_TAPS; // [R20]
    end else begin
      state <= state >> 1; // [R20]
    end
  end

  assign rand_o = state;

  property p_lfsr_nonzero;
    @(posedge clock_i) disable iff (srst_i) state != 8'h00;
  endproperty
  a_lfsr_nonzero: assert property (p_lfsr_nonzero) else $error("lfsr reached zero"); // [R20]
endmodule

// file: test/pipeline_model.sv
// Pipeline model: issues population members and answers selections with records
`timescale 1ns/1ps
module pipeline_model
  import sample_sel_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Stimulus from the bench
  input wire logic issue_i,
  input wire logic sample_select_i,
  input wire logic [15:0] delay_i,
  input wire op_class_t class_i,
  input wire logic [EVENT_W-1:0] events_i,
  input wire logic [LAT_W-1:0] latency_i,
  // Pipeline side
  output logic member_valid_o,
  output logic record_valid_o,
  output op_class_t record_class_o,
  output logic [EVENT_W-1:0] record_events_o,
  output logic [LAT_W-1:0] record_latency_o
);
  logic busy;
  logic [15:0] wait_cnt;
  assign member_valid_o = issue_i;
  // One record per selection taken while idle, after a programmable delay; idle fields are inverted
  always @(posedge clock_i) begin
    #1;
    if (record_valid_o) begin
      record_valid_o = 1'b0;
      record_class_o = op_class_t'(~record_class_o);
      record_events_o = ~record_events_o;
      record_latency_o = ~record_latency_o;
    end
    if (srst_i) begin
      busy = 1'b0;
      wait_cnt = '0;
      record_valid_o = 1'b0;
      record_class_o = CLS_OTHER;
      record_events_o = '0;
      record_latency_o = '0;
    end else if (busy && wait_cnt == 0) begin
      busy = 1'b0;
      record_valid_o = 1'b1;
      record_class_o = class_i;
      record_events_o = events_i;
      record_latency_o = latency_i;
    end else if (busy) begin
      wait_cnt = wait_cnt - 16'd1;
    end else if (sample_select_i === 1'b1) begin
      busy = 1'b1;
      wait_cnt = delay_i;
    end
  end
endmodule

// file: test/profiling_sample_selector_test.sv
// Self-checking bench for the profiling sample selector
`timescale 1ns/1ps
module profiling_sample_selector_test;
  import sample_sel_pkg::*;
  logic clock_i, srst_i, ctrl_write_i, randomize_enable_i, kernel_level_sample_enable_i;
  logic user_level_sample_enable_i, hyp_level_sample_enable_i, host_user_sample_enable_i;
  logic type_filter_enable_i, load_collect_i, store_collect_i, branch_collect_i;
  logic event_filter_enable_i, latency_filter_enable_i, extended_random_mode_i;
  logic buffer_enable_i, buffer_service_i, collision_clear_i, owner_security_select_i;
  logic owner_level_select_i, nonsecure_state_bit_i, host_general_trap_i, debug_state_i;
  logic member_valid_i, record_valid_i, issue, profiling_enabled_o, sample_select_o;
  logic record_keep_o, record_drop_o, collision_event_o, collision_flag_o;
  logic [1:0] writer_level_i, exec_level_i;
  logic [INTERVAL_W-1:0] interval_reload_setting_i;
  logic [EVENT_W-1:0] event_filter_mask_i, record_events_i, re;
  logic [LAT_W-1:0] minimum_latency_i, record_latency_i, rl;
  logic [COUNT_W-1:0] interval_count_state_o;
  logic [RAND_W-1:0] secondary_interval_counter_o, s;
  logic [15:0] delay;
  op_class_t record_class_i, rc;
  int failures, checks, seed, selects, keeps, collisions, k0, n, drops, d0;
  logic want;

  profiling_sample_selector dut_u (.clock_i, .srst_i, .ctrl_write_i, .writer_level_i,
    .interval_reload_setting_i, .randomize_enable_i, .kernel_level_sample_enable_i,
    .user_level_sample_enable_i, .hyp_level_sample_enable_i, .host_user_sample_enable_i,
    .type_filter_enable_i, .load_collect_i, .store_collect_i, .branch_collect_i,
    .event_filter_enable_i, .event_filter_mask_i, .latency_filter_enable_i,
    .minimum_latency_i, .extended_random_mode_i, .buffer_enable_i, .buffer_service_i,
    .collision_clear_i, .owner_security_select_i, .owner_level_select_i,
    .nonsecure_state_bit_i, .host_general_trap_i, .exec_level_i, .debug_state_i,
    .member_valid_i, .record_valid_i, .record_class_i, .record_events_i, .record_latency_i,
    .profiling_enabled_o, .sample_select_o, .record_keep_o, .record_drop_o,
    .collision_event_o, .collision_flag_o, .interval_count_state_o,
    .secondary_interval_counter_o);
  pipeline_model pipe_u (.clock_i(clock_i), .srst_i(srst_i), .issue_i(issue),
    .sample_select_i(sample_select_o), .delay_i(delay), .class_i(rc), .events_i(re),
    .latency_i(rl), .member_valid_o(member_valid_i), .record_valid_o(record_valid_i),
    .record_class_o(record_class_i), .record_events_o(record_events_i),
    .record_latency_o(record_latency_i));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // Event tallies
  always @(posedge clock_i) begin
    selects += (sample_select_o === 1'b1);
    keeps += (record_keep_o === 1'b1);
    drops += (record_drop_o === 1'b1);
    collisions += (collision_event_o === 1'b1);
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic members(input int k);
    if (k > 0) begin
      issue = 1'b1;
      cyc(k);
      issue = 1'b0;
      cyc(2);
    end
  endtask
  task automatic write_ctrl(input logic [1:0] lvl);
    writer_level_i = lvl;
    ctrl_write_i = 1'b1;
    cyc(1);
    ctrl_write_i = 1'b0;
    cyc(2);
  endtask
  task automatic ctx_default();
    {buffer_enable_i, buffer_service_i, debug_state_i, host_general_trap_i} = 4'b1000;
    {owner_security_select_i, owner_level_select_i, nonsecure_state_bit_i} = 3'b000;
    exec_level_i = LEVEL_KERNEL;
    cyc(2);
  endtask
  function automatic logic keep_exp(op_class_t c, logic [63:0] ev, logic [11:0] lat);
    logic t;
    case (c)
      CLS_LOAD: t = load_collect_i;
      CLS_ATOMIC_RET: t = load_collect_i | store_collect_i;
      CLS_STORE, CLS_ATOMIC_NORET: t = store_collect_i;
      CLS_BR_DIRECT, CLS_BR_INDIRECT, CLS_EXC_RETURN: t = branch_collect_i;
      default: t = 1'b0;
    endcase
    return (!type_filter_enable_i || t) && (!latency_filter_enable_i ||
      lat >= minimum_latency_i) && (!event_filter_enable_i || (event_filter_mask_i & ~ev) == 0);
  endfunction
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    failures++;
    close_out();
  end
  initial begin
    {failures, checks, selects, keeps, collisions, drops} = '0;
    seed = 40;
    {ctrl_write_i, randomize_enable_i, user_level_sample_enable_i, host_user_sample_enable_i,
      type_filter_enable_i, load_collect_i, store_collect_i, branch_collect_i} = '0;
    {event_filter_enable_i, latency_filter_enable_i, extended_random_mode_i, buffer_enable_i,
      buffer_service_i, collision_clear_i, owner_security_select_i, issue} = '0;
    {owner_level_select_i, nonsecure_state_bit_i, host_general_trap_i, debug_state_i} = '0;
    {writer_level_i, exec_level_i, event_filter_mask_i, minimum_latency_i} = '0;
    {kernel_level_sample_enable_i, hyp_level_sample_enable_i} = 2'b11;
    interval_reload_setting_i = 24'h00_0001;
    rc = CLS_LOAD;
    re = '0;
    rl = '0;
    delay = 16'h0002;
    srst_i = 1'b1;
    cyc(3);
    srst_i = 1'b0;
    check("enabled", profiling_enabled_o, 0);
    check("count", interval_count_state_o, 0);
    ctx_default();
    write_ctrl(LEVEL_USER);
    check("enabled", profiling_enabled_o, 0);
    write_ctrl(LEVEL_KERNEL);
    check("enabled", profiling_enabled_o, 1);
    check("count", interval_count_state_o, 32'h0000_0100);
    members(10);
    check("count", interval_count_state_o, 32'h0000_00f6);
    debug_state_i = 1'b1;
    n = selects;
    members(5);
    check("enabled", profiling_enabled_o, 0);
    check("count", interval_count_state_o, 32'h0000_00f6);
    check("selects", selects - n, 0);
    ctx_default();
    check("count", interval_count_state_o, 32'h0000_00f6);
    members(245);
    check("count", interval_count_state_o, 32'h0000_0001);
    n = selects;
    k0 = keeps;
    members(1);
    check("count", interval_count_state_o, 32'h0000_0100);
    check("selects", selects - n, 1);
    cyc(6);
    check("kept", keeps - k0, 1);
    for (int i = 0; i < 8; i++) begin
      case (i)
        0: buffer_enable_i = 1'b0;
        1: buffer_service_i = 1'b1;
        2: exec_level_i = LEVEL_HYP;
        3: nonsecure_state_bit_i = 1'b1;
        4: debug_state_i = 1'b1;
        5: exec_level_i = LEVEL_USER;
        6: {owner_security_select_i, owner_level_select_i, nonsecure_state_bit_i,
          host_general_trap_i, exec_level_i} = {4'b1111, LEVEL_USER};
        default: {owner_security_select_i, owner_level_select_i, nonsecure_state_bit_i,
          exec_level_i} = {3'b111, LEVEL_HYP};
      endcase
      cyc(1);
      check("enabled", profiling_enabled_o, i == 7);
      ctx_default();
    end
    for (int i = 0; i < 20; i++) begin
      {type_filter_enable_i, load_collect_i, store_collect_i, branch_collect_i} = 4'($random(seed));
      {event_filter_enable_i, latency_filter_enable_i} = 2'($random(seed));
      event_filter_mask_i = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
      event_filter_mask_i &= {$random(seed), $random(seed)};
      minimum_latency_i = 12'($random(seed));
      rc = op_class_t'(3'($random(seed)));
      re = {$random(seed), $random(seed)} | (i[0] ? event_filter_mask_i : 64'h0);
      rl = (i < 2) ? minimum_latency_i : 12'($random(seed));
      write_ctrl(2'(($unsigned($random(seed)) % 3) + 1));
      want = keep_exp(rc, re, rl);
      k0 = keeps;
      d0 = drops;
      n = collisions;
      members(256);
      cyc(8);
      check("kept", keeps - k0, want);
      check("dropped", drops - d0, !want);
      check("collision", collisions - n, 0);
    end
    delay = 16'd400;
    n = collisions;
    members(512);
    check("collision", collisions - n, 1);
    check("flag", collision_flag_o, 1);
    cyc(450);
    collision_clear_i = 1'b1;
    cyc(1);
    collision_clear_i = 1'b0;
    cyc(2);
    check("flag", collision_flag_o, 0);
    delay = 16'd2;
    {randomize_enable_i, extended_random_mode_i, type_filter_enable_i} = 3'b110;
    {event_filter_enable_i, latency_filter_enable_i} = 2'b00;
    write_ctrl(LEVEL_HYP);
    n = 0;
    while (secondary_interval_counter_o === 8'h00 && n < 600) begin
      members(1);
      n++;
    end
    check("secondary", secondary_interval_counter_o != 0, 1);
    s = secondary_interval_counter_o;
    n = selects;
    members(1);
    check("secondary", secondary_interval_counter_o, s - 8'h01);
    members(int'(s) - 1);
    check("selects", selects - n, 1);
    // Randomized mode 0: reload keeps the interval and takes a random low byte
    extended_random_mode_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      n = selects;
      members(int'(interval_count_state_o));
      check("interval", interval_count_state_o[31:8], 24'h00_0001);
      check("low", interval_count_state_o[7:0] != 8'h00, 1);
      check("selects", selects - n, 1);
    end
    close_out();
  end
endmodule
